// ### bench/sfm_host_model.sv
`timescale 1ns/1ps
module sfm_host_model (
  // Clock
  input  wire logic        core_clk,
  // Avalon-MM master side
  output logic [3:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable,
  input  wire logic        waitrequest
);
  // Idle bus from time zero so nothing is taken during reset
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
  end
  // One access; request held until waitrequest is seen low, then released
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk); // Gap so a following access never lands in the same step
  endtask
endmodule // sfm_host_model

// ### bench/sfm_supply_fault_monitor_monitor.sv
`timescale 1ns/1ps
module sfm_supply_fault_monitor_monitor (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Comparators and phase state
  input wire logic        posOvercurrentCmp,
  input wire logic        posUndervoltageCmp,
  input wire logic        negUndervoltageCmp,
  input wire logic        phaseDriversOff,
  // Outputs under watch
  input wire logic [6:0]  posOvercurrentThresholdCode,
  input wire logic        nominalVoltageSelect,
  input wire logic        faultOutput_n,
  input wire logic        bridgeDriverOff,
  input wire logic        phaseLatchOff
);
  // ==========================================================
  // Helpers
  logic regWr;
  logic cfgWr;
  assign regWr = write && !waitrequest;
  assign cfgWr = regWr && address == sfm_pkg::ADDR_CONFIG;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Bus timing: one wait state, answer stands one cycle
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer one cycle after request");
  property p_stand; !waitrequest |=> waitrequest; endproperty
  a_stand: assert property (p_stand) else $error("answer held longer than one cycle");
  property p_unmap;
    read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // ==========================================================
  // Settings reach the analog trims only through a config write
  // Register takes the write at the accepting edge, the trim flop one edge later
  property p_code;
    cfgWr |-> ##2 posOvercurrentThresholdCode == $past(writedata[6:0], 2);
  endproperty
  a_code: assert property (p_code) else $error("threshold code not taken");
  property p_codeHold; $changed(posOvercurrentThresholdCode) |-> $past(cfgWr, 2); endproperty
  a_codeHold: assert property (p_codeHold) else $error("threshold moved unasked");
  property p_nomv; cfgWr |-> ##2 nominalVoltageSelect == $past(writedata[12], 2); endproperty
  a_nomv: assert property (p_nomv) else $error("nominal select not taken");
  // ==========================================================
  // Fault output and latches move only for their causes
  property p_fall;
    $fell(faultOutput_n) |->
      $past(posOvercurrentCmp || posUndervoltageCmp || negUndervoltageCmp, 3);
  endproperty
  a_fall: assert property (p_fall) else $error("fault output fell with no fault");
  property p_rise; $rose(faultOutput_n) |-> $past(regWr, 1) || $past(regWr, 2); endproperty
  a_rise: assert property (p_rise) else $error("fault output released unasked");
  property p_brg; $fell(bridgeDriverOff) |-> $past(regWr, 1) || $past(regWr, 2); endproperty
  a_brg: assert property (p_brg) else $error("bridge latch dropped unasked");
  // Phase latch may only hold drivers that were already off
  // Pin passes the synchroniser before the latch sees it
  property p_phase;
    $rose(phaseLatchOff) |-> $past(phaseDriversOff, 5) || $past(phaseDriversOff, 6);
  endproperty
  a_phase: assert property (p_phase) else $error("phase latched while on");
endmodule // sfm_supply_fault_monitor_monitor

bind sfm_supply_fault_monitor sfm_supply_fault_monitor_monitor i_mon (
  .core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .posOvercurrentCmp(posOvercurrentCmp), .posUndervoltageCmp(posUndervoltageCmp),
  .negUndervoltageCmp(negUndervoltageCmp), .phaseDriversOff(phaseDriversOff),
  .posOvercurrentThresholdCode(posOvercurrentThresholdCode),
  .nominalVoltageSelect(nominalVoltageSelect), .faultOutput_n(faultOutput_n),
  .bridgeDriverOff(bridgeDriverOff), .phaseLatchOff(phaseLatchOff));

// ### bench/sfm_supply_fault_monitor_tb.sv
`timescale 1ns/1ps
module sfm_supply_fault_monitor_tb;
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  address, byteenable;
  logic        read, write, waitrequest;
  logic [31:0] writedata, readdata, lastRd;
  logic        posOvercurrentCmp, negOvercurrentCmp, negOvercurrentQualified;
  logic        posUndervoltageCmp, negUndervoltageCmp, phaseDriversOff;
  logic [6:0]  posOvercurrentThresholdCode, code;
  logic        nominalVoltageSelect, faultOutput_n;
  logic        bridgeDriverOff, reverseDriverOff, phaseLatchOff;
  int          n_mismatch = 0;
  int          checked = 0;
  integer      seed = 58874;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];

  always #5 core_clk = ~core_clk;

  sfm_supply_fault_monitor i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .posOvercurrentCmp(posOvercurrentCmp), .negOvercurrentCmp(negOvercurrentCmp),
    .negOvercurrentQualified(negOvercurrentQualified),
    .posUndervoltageCmp(posUndervoltageCmp), .negUndervoltageCmp(negUndervoltageCmp),
    .phaseDriversOff(phaseDriversOff),
    .posOvercurrentThresholdCode(posOvercurrentThresholdCode),
    .nominalVoltageSelect(nominalVoltageSelect), .faultOutput_n(faultOutput_n),
    .bridgeDriverOff(bridgeDriverOff), .reverseDriverOff(reverseDriverOff),
    .phaseLatchOff(phaseLatchOff));
  sfm_host_model i_host (.core_clk(core_clk), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .waitrequest(waitrequest));

  // ==========================================================
  // Tasks
  task automatic cmp(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    checked++;
    if (((g ^ e) & m) !== 32'h0000_0000) begin
      n_mismatch++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Pins as {fault_n, bridge, reverse, phase}, looked at mid-cycle when settled
  task automatic pins(input logic [31:0] e);
    @(negedge core_clk);
    cmp(e, {28'h000_0000, faultOutput_n, bridgeDriverOff, reverseDriverOff, phaseLatchOff},
        32'h0000_000F);
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    i_host.acc(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_host.acc(1'b1, a, d);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Scoreboard: each read answer is matched against the oldest note
  always @(posedge core_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      lastRd <= readdata;
      cmp(expQ.pop_front(), readdata, mskQ.pop_front());
    end
  end

  // Watchdog; the whole sequence needs well under two thousand cycles
  initial begin
    hold(20000);
    n_mismatch++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {posOvercurrentCmp, negOvercurrentCmp, negOvercurrentQualified} = 3'h0;
    {posUndervoltageCmp, negUndervoltageCmp, phaseDriversOff} = 3'h0;
    hold(10);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(sfm_pkg::ADDR_CONFIG, sfm_pkg::CFG_RESET, '1);
    rd(sfm_pkg::ADDR_ACTION, sfm_pkg::ACT_RESET, '1);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0000, '1);
    rd(4'h6, sfm_pkg::UNMAPPED_DATA, '1);
    pins(32'h0000_0008);
    // Random threshold, 48 V select, qualify delay 2 (50 cycles)
    code = 7'($random(seed));
    wr(sfm_pkg::ADDR_CONFIG, 32'h0000_1200 | 32'(code));
    rd(sfm_pkg::ADDR_CONFIG, 32'h0000_1200 | 32'(code), '1);
    cmp(32'(code), 32'(posOvercurrentThresholdCode), '1);
    cmp(32'h0000_0001, 32'(nominalVoltageSelect), '1);
    wr(sfm_pkg::ADDR_ACTION, 32'h0000_0077);
    // Pulse shorter than the delay must not qualify, a long one must
    posOvercurrentCmp <= 1'b1;
    hold(40);
    posOvercurrentCmp <= 1'b0;
    hold(10);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0001);
    posOvercurrentCmp <= 1'b1;
    hold(70);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0301, '1);
    pins(32'h0000_0006);
    wr(sfm_pkg::ADDR_STATUS, 32'h0000_0001);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    posOvercurrentCmp <= 1'b0;
    hold(10);
    wr(sfm_pkg::ADDR_STATUS, 32'h0000_0001);
    pins(32'h0000_0008);
    // Masked overcurrent keeps the fault output high
    wr(sfm_pkg::ADDR_CONFIG, 32'h0001_0100);
    posOvercurrentCmp <= 1'b1;
    hold(40);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    pins(32'h0000_000E);
    posOvercurrentCmp <= 1'b0;
    hold(10);
    wr(sfm_pkg::ADDR_STATUS, 32'h0000_0001);
    // Positive undervoltage with current-dependent isolation, phases off
    wr(sfm_pkg::ADDR_CONFIG, 32'h0000_2100);
    phaseDriversOff <= 1'b1;
    posUndervoltageCmp <= 1'b1;
    hold(20);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0502, '1);
    negOvercurrentQualified <= 1'b1;
    hold(10);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0702, '1);
    posUndervoltageCmp <= 1'b0;
    negOvercurrentQualified <= 1'b0;
    hold(10);
    wr(sfm_pkg::ADDR_STATUS, 32'h0000_0002);
    hold(2); // Phase latch output trails the flag by two flops
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0000, '1);
    // Negative undervoltage with all actions off
    negUndervoltageCmp <= 1'b1;
    hold(20);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0004, '1);
    pins(32'h0000_0000);
    negUndervoltageCmp <= 1'b0;
    phaseDriversOff <= 1'b0;
    hold(10);
    wr(sfm_pkg::ADDR_STATUS, 32'h0000_0004);
    pins(32'h0000_0008);
    // Interval timer at prescale 8, stopped by a negative overcurrent
    wr(sfm_pkg::ADDR_TIMER, 32'h0000_0031);
    rd(sfm_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
    hold(200);
    negOvercurrentCmp <= 1'b1;
    hold(10);
    negOvercurrentCmp <= 1'b0;
    rd(sfm_pkg::ADDR_TIMER, 32'h0000_0000, 32'h0000_0000);
    hold(1);
    cmp(32'h0000_0001, 32'(lastRd[15:8] >= 8'h16 && lastRd[15:8] <= 8'h1D), '1);
    wr(sfm_pkg::ADDR_STATUS, 32'h0000_0008);
    wr(sfm_pkg::ADDR_TIMER, 32'h0000_0002);
    hold(40);
    rd(sfm_pkg::ADDR_TIMER, 32'h0000_0000, 32'h0000_FF02);
    wr(sfm_pkg::ADDR_TIMER, 32'h0000_0000);
    wr(sfm_pkg::ADDR_TIMER, 32'h0000_0001);
    hold(300);
    rd(sfm_pkg::ADDR_TIMER, 32'h0000_FF01, 32'h0000_FF03);
    wr(sfm_pkg::ADDR_TIMER, 32'h0000_0000);
    rd(sfm_pkg::ADDR_TIMER, 32'h0000_0000, 32'h0000_FF01);
    hold(5);
    close_out();
  end
endmodule // sfm_supply_fault_monitor_tb

// ### hdl/sfm_pkg.sv
package sfm_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned QUAL_TICK_NS   = 250;
  localparam int unsigned QUAL_TICK_CYC  = QUAL_TICK_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Register word offsets (byte addresses)
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_ACTION  = 4'h4;
  localparam logic [3:0] ADDR_TIMER   = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hC;
  // ==========================================================
  // Config register fields
  localparam int unsigned CFG_THR_LSB   = 0;   // 7-bit threshold code
  localparam int unsigned CFG_DLY_LSB   = 8;   // 3-bit qualify delay
  localparam int unsigned CFG_NOMV_BIT  = 12;
  localparam int unsigned CFG_ISO_BIT   = 13;
  localparam int unsigned CFG_MOC_BIT   = 16;  // fault_output_n masks
  localparam int unsigned CFG_MUVP_BIT  = 17;
  localparam int unsigned CFG_MUVN_BIT  = 18;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0100;
  // Action register: per fault {phase, reverse, bridge} at base 0/4/8
  localparam int unsigned ACT_OC_LSB    = 0;
  localparam int unsigned ACT_UVP_LSB   = 4;
  localparam int unsigned ACT_UVN_LSB   = 8;
  localparam logic [31:0] ACT_RESET     = 32'h0000_0000;
  // Timer register fields
  localparam int unsigned TMR_EN_BIT    = 0;
  localparam int unsigned TMR_RST_BIT   = 1;
  localparam int unsigned TMR_PRE_LSB   = 4;
  localparam int unsigned TMR_CNT_LSB   = 8;
  // Status register fields (bits 0 to 3 write 1 to clear; latch states 8 to 10 read only)
  localparam int unsigned ST_OC_BIT     = 0;
  localparam int unsigned ST_UVP_BIT    = 1;
  localparam int unsigned ST_UVN_BIT    = 2;
  localparam int unsigned ST_TRST_BIT   = 3;
  localparam int unsigned ST_BRG_BIT    = 8;   // driver latch states
  localparam int unsigned ST_REV_BIT    = 9;
  localparam int unsigned ST_PH_BIT     = 10;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ### hdl/sfm_supply_fault_monitor.sv
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module sfm_supply_fault_monitor (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Analog comparator outputs, asynchronous
  input  wire logic        posOvercurrentCmp,
  input  wire logic        negOvercurrentCmp,
  input  wire logic        negOvercurrentQualified,
  input  wire logic        posUndervoltageCmp,
  input  wire logic        negUndervoltageCmp,
  // Phase driver state from gate control
  input  wire logic        phaseDriversOff,
  // Settings to analog trims
  output logic [6:0]       posOvercurrentThresholdCode,
  output logic             nominalVoltageSelect,
  // Fault actions
  output logic             faultOutput_n,
  output logic             bridgeDriverOff,
  output logic             reverseDriverOff,
  output logic             phaseLatchOff
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Three-stage sync, change valid when stages 2 and 3 agree
  function automatic logic sync_filter(input logic s2, input logic s3, input logic prev);
    return (s2 == s3) ? s3 : prev;
  endfunction

  // ==========================================================
  // Bus handshake: one wait cycle, answer on the second edge
  logic        acc_q;
  logic        busReq;
  logic        accept;
  assign busReq = read | write;
  assign accept = busReq & acc_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= busReq & ~acc_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(busReq & ~acc_q);
    end
  end

  logic wrCfg, wrAct, wrTmr, wrSt;
  assign wrCfg = accept & write & (address == sfm_pkg::ADDR_CONFIG);
  assign wrAct = accept & write & (address == sfm_pkg::ADDR_ACTION);
  assign wrTmr = accept & write & (address == sfm_pkg::ADDR_TIMER);
  assign wrSt  = accept & write & (address == sfm_pkg::ADDR_STATUS);

  // ==========================================================
  // Configuration and action registers
  logic [31:0] cfg_q;
  logic [31:0] act_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= sfm_pkg::CFG_RESET;                    // nominal voltage 0 = 12 V
    end else if (wrCfg) begin
      cfg_q <= be_merge(cfg_q, writedata, byteenable);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_q <= sfm_pkg::ACT_RESET;
    end else if (wrAct) begin
      act_q <= be_merge(act_q, writedata, byteenable);
    end
  end

  logic [2:0] qualDelay;
  logic       isoSel;
  assign qualDelay = cfg_q[sfm_pkg::CFG_DLY_LSB +: 3];
  assign isoSel    = cfg_q[sfm_pkg::CFG_ISO_BIT];

  // Threshold code and voltage select go straight out of flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      posOvercurrentThresholdCode <= 7'h00;
      nominalVoltageSelect        <= 1'b0;
    end else begin
      posOvercurrentThresholdCode <= cfg_q[sfm_pkg::CFG_THR_LSB +: 7];
      nominalVoltageSelect        <= cfg_q[sfm_pkg::CFG_NOMV_BIT];
    end
  end

  // ==========================================================
  // Comparator and phase-state synchronisers; the phase pin is asynchronous too
  logic [5:0] s1_q, s2_q, s3_q, cmp_q;
  logic [5:0] cmpRaw;
  assign cmpRaw = {phaseDriversOff, negOvercurrentQualified, negUndervoltageCmp,
                   posUndervoltageCmp, negOvercurrentCmp, posOvercurrentCmp};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q  <= 6'h00;
      s2_q  <= 6'h00;
      s3_q  <= 6'h00;
      cmp_q <= 6'h00;
    end else begin
      s1_q <= cmpRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 6; i++) begin
        cmp_q[i] <= sync_filter(s2_q[i], s3_q[i], cmp_q[i]);
      end
    end
  end

  logic pos_overcurrent_threshold_code, neg_overcurrent_threshold_code, uvP, uvN, negAbove, phOff;
  assign phOff    = cmp_q[5];
  assign pos_overcurrent_threshold_code      = cmp_q[0];
  assign neg_overcurrent_threshold_code      = cmp_q[1];
  assign uvP      = cmp_q[2];
  assign uvN      = cmp_q[3];
  assign negAbove = cmp_q[4];

  // ==========================================================
  // Positive overcurrent qualifier, 250 ns tick
  logic [4:0] tick_q;
  logic       tick;
  logic [2:0] qual_q;
  logic       ocQual_q;
  assign tick = (tick_q == 5'(sfm_pkg::QUAL_TICK_CYC - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 5'h00;
    end else if (!pos_overcurrent_threshold_code || tick) begin
      tick_q <= 5'h00;
    end else begin
      tick_q <= tick_q + 5'h01;
    end
  end

  // Delay 0 is treated as one tick, as n must be positive
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      qual_q   <= 3'h0;
      ocQual_q <= 1'b0;
    end else if (!pos_overcurrent_threshold_code) begin
      qual_q   <= 3'h0;
      ocQual_q <= 1'b0;
    end else if (tick && !ocQual_q) begin
      qual_q <= qual_q + 3'h1;
      if (qual_q + 3'h1 >= qualDelay) begin
        ocQual_q <= 1'b1;
      end
    end
  end

  // Undervoltage events arrive already validated by the analog side
  logic ocEvt, uvpEvt, uvnEvt;
  assign ocEvt  = ocQual_q;
  assign uvpEvt = uvP;
  assign uvnEvt = uvN;

  // ==========================================================
  // Sticky flags: set wins; clear only when condition gone
  logic flagOc_q, flagUvp_q, flagUvn_q;
  logic clrOc, clrUvp, clrUvn;
  assign clrOc  = wrSt & byteenable[0] & writedata[sfm_pkg::ST_OC_BIT] & ~ocEvt;
  assign clrUvp = wrSt & byteenable[0] & writedata[sfm_pkg::ST_UVP_BIT] & ~uvpEvt;
  assign clrUvn = wrSt & byteenable[0] & writedata[sfm_pkg::ST_UVN_BIT] & ~uvnEvt;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flagOc_q  <= 1'b0;
      flagUvp_q <= 1'b0;
      flagUvn_q <= 1'b0;
    end else begin
      flagOc_q  <= ocEvt  | (flagOc_q  & ~clrOc);
      flagUvp_q <= uvpEvt | (flagUvp_q & ~clrUvp);
      flagUvn_q <= uvnEvt | (flagUvn_q & ~clrUvn);
    end
  end

  // Fault output low while any unmasked flag stands
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      faultOutput_n <= 1'b1;
    end else begin
      faultOutput_n <= ~((flagOc_q  & ~cfg_q[sfm_pkg::CFG_MOC_BIT])
                       | (flagUvp_q & ~cfg_q[sfm_pkg::CFG_MUVP_BIT])
                       | (flagUvn_q & ~cfg_q[sfm_pkg::CFG_MUVN_BIT]));
    end
  end

  // ==========================================================
  // Driver latches; each released when its causing flag is gone
  logic [2:0] flags, brgAct, revAct, phAct;
  assign flags  = {flagUvn_q, flagUvp_q, flagOc_q};
  assign brgAct = {act_q[sfm_pkg::ACT_UVN_LSB], act_q[sfm_pkg::ACT_UVP_LSB],
                   act_q[sfm_pkg::ACT_OC_LSB]};
  assign revAct = {act_q[sfm_pkg::ACT_UVN_LSB+1], act_q[sfm_pkg::ACT_UVP_LSB+1],
                   act_q[sfm_pkg::ACT_OC_LSB+1]};
  assign phAct  = {act_q[sfm_pkg::ACT_UVN_LSB+2], act_q[sfm_pkg::ACT_UVP_LSB+2],
                   act_q[sfm_pkg::ACT_OC_LSB+2]};

  logic [2:0] phHold_q;
  logic       revTrig;
  // Current-dependent isolation gates reverse latch on negative overcurrent level
  assign revTrig = |(flags & revAct) & (~isoSel | negAbove);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bridgeDriverOff  <= 1'b0;
      reverseDriverOff <= 1'b0;
    end else begin
      bridgeDriverOff  <= |(flags & brgAct);
      reverseDriverOff <= revTrig | (reverseDriverOff & |(flags & revAct));
    end
  end

  // Phase latch only captures when phases are already off
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phHold_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        phHold_q[i] <= flags[i] & phAct[i] & (phHold_q[i] | phOff);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phaseLatchOff <= 1'b0;
    end else begin
      phaseLatchOff <= |phHold_q;
    end
  end

  // ==========================================================
  // Overcurrent interval timer
  logic       tmrEn_q, tmrEnPrev_q, running_q, tmrRstInd_q, ocAnyPrev_q;
  logic [1:0] pre_q;
  logic [2:0] preCnt_q;
  logic [7:0] count_q;
  logic       ocAny, enRise, rstReq, clrTrst;
  assign ocAny   = ocQual_q | neg_overcurrent_threshold_code;
  assign enRise  = tmrEn_q & ~tmrEnPrev_q;
  assign rstReq  = wrTmr & byteenable[0] & writedata[sfm_pkg::TMR_RST_BIT];
  assign clrTrst = wrSt & byteenable[0] & writedata[sfm_pkg::ST_TRST_BIT];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tmrEn_q     <= 1'b0;
      tmrEnPrev_q <= 1'b0;
      pre_q       <= 2'h0;                            // prescale 1 by default
      ocAnyPrev_q <= 1'b0;
    end else begin
      tmrEnPrev_q <= tmrEn_q;
      ocAnyPrev_q <= ocAny;
      if (wrTmr && byteenable[0]) begin
        tmrEn_q <= writedata[sfm_pkg::TMR_EN_BIT];
        pre_q   <= writedata[sfm_pkg::TMR_PRE_LSB +: 2];
      end
    end
  end

  // Prescale factor is 2^field: 1, 2, 4, 8
  logic preTick;
  assign preTick = (preCnt_q == 3'((4'h1 << pre_q) - 4'h1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      running_q <= 1'b0;
      preCnt_q  <= 3'h0;
      count_q   <= 8'h00;
    end else if (!tmrEn_q || rstReq) begin
      running_q <= 1'b0;
      preCnt_q  <= 3'h0;
      count_q   <= 8'h00;
    end else if (enRise) begin
      running_q <= 1'b1;
      preCnt_q  <= 3'h0;
      count_q   <= 8'h00;
    end else if (running_q) begin
      if (ocAny && !ocAnyPrev_q) begin
        running_q <= 1'b0;                            // stop on first overcurrent
      end else begin
        preCnt_q <= preTick ? 3'h0 : preCnt_q + 3'h1;
        if (preTick && count_q != 8'hFF) begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  // Reset bit always reads back 0; indication sticky until cleared
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tmrRstInd_q <= 1'b0;
    end else begin
      tmrRstInd_q <= enRise | (tmrRstInd_q & ~clrTrst);
    end
  end

  // ==========================================================
  // Read data
  logic [31:0] rdMux;
  always_comb begin
    rdMux = sfm_pkg::UNMAPPED_DATA;
    case (address)
      sfm_pkg::ADDR_CONFIG: rdMux = cfg_q;
      sfm_pkg::ADDR_ACTION: rdMux = act_q;
      sfm_pkg::ADDR_TIMER: begin
        rdMux[sfm_pkg::TMR_EN_BIT]        = tmrEn_q;
        rdMux[sfm_pkg::TMR_PRE_LSB +: 2]  = pre_q;
        rdMux[sfm_pkg::TMR_CNT_LSB +: 8]  = count_q;
      end
      sfm_pkg::ADDR_STATUS: begin
        rdMux[sfm_pkg::ST_OC_BIT]   = flagOc_q;
        rdMux[sfm_pkg::ST_UVP_BIT]  = flagUvp_q;
        rdMux[sfm_pkg::ST_UVN_BIT]  = flagUvn_q;
        rdMux[sfm_pkg::ST_TRST_BIT] = tmrRstInd_q;
        rdMux[sfm_pkg::ST_BRG_BIT]  = bridgeDriverOff;
        rdMux[sfm_pkg::ST_REV_BIT]  = reverseDriverOff;
        rdMux[sfm_pkg::ST_PH_BIT]   = phaseLatchOff;
      end
      default: rdMux = sfm_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !acc_q) begin
      readdata <= rdMux;
    end
  end

endmodule // sfm_supply_fault_monitor
